// File: shared/fdh_map.vh
// Purpose: register map, field positions and codes for the link frame receiver
// Assumes: register indices are multiplied by four to form AHB byte addresses
// Notes: the register indices, field positions, codes and link constants the design files share live here
`ifndef FDH_MAP_VH
`define FDH_MAP_VH

`define FDH_IDX_CFG 8'h38
`define FDH_IDX_IRQ 8'h39
`define FDH_IDX_STAT 8'h3A
`define FDH_IDX_DATA 8'h3B

`define FDH_CFG_EN 0
`define FDH_CFG_TR 1
`define FDH_IRQ_INT 0
`define FDH_IRQ_SEL_LO 1
`define FDH_IRQ_SEL_HI 2

`define FDH_ENT_W 14
`define FDH_ENT_EOM 13
`define FDH_ENT_FLG 12
`define FDH_ENT_CRC 11
`define FDH_NVB_RST 3'h7
`define FDH_STAT_RST 6'h07

`define FDH_FIFO_AW 2
`define FDH_ONES_FLAG 3'h6
`define FDH_ONES_STUFF 3'h5
`define FDH_ONES_MAX 3'h7
`define FDH_DLY_FULL 3'h7

`define FDH_CRC_INIT 16'hFFFF
`define FDH_CRC_POLY 16'h8408
`define FDH_CRC_GOOD 16'hF0B8

`endif

// File: design/fdh_crc16.v
// Purpose: bit-serial frame check accumulator, first bit in at the low end
// Assumes: one bit per strobe, init dominates a strobe
// Notes: a good frame leaves the fixed residue in the register
`include "fdh_map.vh"
`timescale 1ns/1ps
module fdh_crc16 (
	input wire clock_in,
	input wire rst_in,
	input wire init_in,
	input wire bit_stb_in,
	input wire bit_in,
	output wire [15:0] crc_out
);
reg [15:0] crc_q;
wire fb = crc_q[0] ^ bit_in;

always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		crc_q <= `FDH_CRC_INIT;
	end else if (init_in) begin
		crc_q <= `FDH_CRC_INIT;
	end else if (bit_stb_in) begin
		crc_q <= {1'b0, crc_q[15:1]} ^ (fb ? `FDH_CRC_POLY : 16'h0000);
	end
end

assign crc_out = crc_q;
endmodule

// File: design/fdh_entry_fifo.v
// Purpose: small first-in first-out store of data bytes with their status
// Assumes: writes to a full store are dropped, the caller flags the overrun
// Notes: clear wins over write and read
`timescale 1ns/1ps
module fdh_entry_fifo #(
	parameter WIDTH = 14,
	parameter AW = 2
) (
	input wire clock_in,
	input wire rst_in,
	input wire clear_in,
	input wire wr_in,
	input wire [WIDTH-1:0] wdata_in,
	input wire rd_in,
	output wire [WIDTH-1:0] rdata_out,
	output wire [AW:0] count_out,
	output wire full_out,
	output wire empty_out
);
localparam DEPTH = 1 << AW;
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wp_q;
reg [AW-1:0] rp_q;
reg [AW:0] cnt_q;
wire do_wr = wr_in & ~full_out;
wire do_rd = rd_in & ~empty_out;

always @(posedge clock_in) begin
	if (do_wr) begin
		mem[wp_q] <= wdata_in;
	end
end

always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		wp_q <= {AW{1'b0}};
		rp_q <= {AW{1'b0}};
		cnt_q <= {(AW+1){1'b0}};
	end else if (clear_in) begin
		wp_q <= {AW{1'b0}};
		rp_q <= {AW{1'b0}};
		cnt_q <= {(AW+1){1'b0}};
	end else begin
		if (do_wr) wp_q <= wp_q + 1'b1;
		if (do_rd) rp_q <= rp_q + 1'b1;
		if (do_wr & ~do_rd) cnt_q <= cnt_q + 1'b1;
		else if (do_rd & ~do_wr) cnt_q <= cnt_q - 1'b1;
	end
end

assign rdata_out = mem[rp_q];
assign count_out = cnt_q;
assign full_out = (cnt_q == DEPTH[AW:0]);
assign empty_out = (cnt_q == {(AW+1){1'b0}});
endmodule

// File: design/fdh_link_frame_receiver.v
// Purpose: serial data-link frame receiver with byte store, status and interrupt
// Assumes: rx_bit_stb_in pulses one cycle per link bit, pulses at least 2 cycles apart
// Notes: registers sit at byte address 4 x index on an AHB-Lite slave, one wait state
// Notes on behaviour
// - clearing enable empties store and interrupts, keeps select; enabling hunts flags
// - terminate aborts frame, empties store, clears interrupts, restarts hunt
// - terminate bit clears itself one cycle later and then reads zero
// - first flag after terminate or re-enable raises an interrupt
// - select 00 off, 01 any byte, 10 two bytes, 11 three bytes held
// - status bit follows the output; with select 00 it shows the internal latch
// - end of message, overrun, abort and first flag also interrupt
// - data read emptying store clears latch; overrun irq clears on status read
// - valid count is bits minus one, filled from the top, resets to 111
// - valid count and check error only mean something on a real frame end
// - check error set when the finished frame fails its frame check
// - end of message marks last byte, abort byte, dummy byte, and overrun
// - end of message and flag seen travel with each byte
// - flag seen set by flag, cleared by abort, seven or eight ones, disable
// - store empty high after last read, low on load, resets high
// - read of empty store does not advance; next status read is zero
// - four-entry store, bit 0 is first bit, pointer moves after the read
// - overrun interrupts and holds the store cleared until status read
// - abort interrupts and stores the partly shifted byte
`include "fdh_map.vh"
`timescale 1ns/1ps
module fdh_link_frame_receiver #(
	parameter FIFO_AW = `FDH_FIFO_AW
) (
	input wire clock_in,
	input wire rst_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output wire hreadyout_out,
	output wire [31:0] hrdata_out,
	output wire hresp_out,
	input wire rx_bit_in,
	input wire rx_bit_stb_in,
	output wire rx_link_irq_out,
	output wire rx_frame_end_out
);
localparam ST_ONES = 3'b001;
localparam ST_FLAGS = 3'b010;
localparam ST_FRAME = 3'b100;
localparam EW = `FDH_ENT_W;

function [EW-1:0] mk_ent;
	input end_of_message;
	input flag_seen;
	input crc;
	input [2:0] nvb;
	input [7:0] d;
	begin
		mk_ent = {end_of_message, flag_seen, crc, nvb, d};
	end
endfunction

reg en_q;
reg tr_q;
reg [1:0] sel_q;
reg ap_q;
reg ap_wr_q;
reg ap_hit_q;
reg [7:0] ap_idx_q;
reg hready_q;
reg hresp_q;
reg [31:0] hrdata_q;
reg [2:0] st_q;
reg [2:0] ones_q;
reg [6:0] dly_q;
reg [2:0] dcnt_q;
reg [7:0] asm_q;
reg [2:0] n_q;
reg [7:0] pend_q;
reg pend_v_q;
reg tail_q;
reg [EW-1:0] tail_ent_q;
reg flg_q;
reg ovr_q;
reg ovr_irq_q;
reg lat_q;
reg und_q;
reg [5:0] stat_q;
reg irq_q;
reg eom_out_q;

reg fifo_wr;
reg [EW-1:0] fifo_ent;
reg tail_d;
reg [EW-1:0] tail_ent_d;
reg has_f;
reg [EW-1:0] f_ent;
wire [EW-1:0] fifo_head;
wire [FIFO_AW:0] fifo_cnt;
wire fifo_full;
wire fifo_empty;
wire [15:0] crc_val;

// register bus decode, acts in the data phase
wire hit_cfg = ap_q & ap_hit_q & (ap_idx_q == `FDH_IDX_CFG);
wire hit_irq = ap_q & ap_hit_q & (ap_idx_q == `FDH_IDX_IRQ);
wire hit_stat = ap_q & ap_hit_q & (ap_idx_q == `FDH_IDX_STAT);
wire hit_data = ap_q & ap_hit_q & (ap_idx_q == `FDH_IDX_DATA);
wire wr_cfg = hit_cfg & ap_wr_q;
wire wr_irq = hit_irq & ap_wr_q;
wire rd_stat = hit_stat & ~ap_wr_q;
wire rd_data = hit_data & ~ap_wr_q;

wire restart = ~en_q | tr_q;
wire kill = restart | ovr_q;
wire stb = rx_bit_stb_in & ~kill;
wire hunting = (st_q == ST_ONES);
wire is_flag = ~rx_bit_in & (ones_q == `FDH_ONES_FLAG);
wire is_abort = rx_bit_in & (ones_q == `FDH_ONES_FLAG);
wire stuffed = ~rx_bit_in & (ones_q == `FDH_ONES_STUFF);
wire push = stb & ~hunting & ~is_flag & ~is_abort & ~stuffed;
// the last seven pushed bits may be a closing flag, so data lags by seven
wire exit_b = push & (dcnt_q == `FDH_DLY_FULL);
wire [7:0] asm_nx = {dly_q[6], asm_q[7:1]};
wire byte_done = exit_b & (n_q == 3'h7);
wire end_frame = stb & is_flag & (st_q == ST_FRAME);
wire ev_abort = stb & is_abort & ~hunting;
wire ev_first = stb & is_flag & hunting;
wire crc_bad = (crc_val != `FDH_CRC_GOOD);
wire crc_init = kill | (stb & (is_flag | is_abort));
wire fifo_rd = rd_data & ~fifo_empty & ~kill;
wire fill_hit = (sel_q != 2'b00) & (fifo_cnt >= {{(FIFO_AW-1){1'b0}}, sel_q});
wire eom_wr = fifo_wr & fifo_ent[`FDH_ENT_EOM] & ~kill;
// a pop never raises the fill level, so the emptying read can clear the latch
wire lat_set = ev_first | ev_abort | eom_wr | (fill_hit & ~kill & ~fifo_rd);
wire lat_clr = restart | (fifo_rd & (fifo_cnt == {{FIFO_AW{1'b0}}, 1'b1}));
wire ovr_set = fifo_wr & fifo_full & ~kill;
wire int_bit = (sel_q != 2'b00) ? irq_q : (lat_q | ovr_irq_q);
wire eom_view = ovr_q | stat_q[5];
wire [7:0] stat_byte = und_q ? 8'h00 :
	{fifo_empty, ovr_q, ~ovr_q & stat_q[4], eom_view, stat_q[3:0]};

fdh_crc16 u_crc (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.init_in(crc_init),
	.bit_stb_in(exit_b),
	.bit_in(dly_q[6]),
	.crc_out(crc_val)
);

fdh_entry_fifo #(
	.WIDTH(EW),
	.AW(FIFO_AW)
) u_fifo (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.clear_in(kill),
	.wr_in(fifo_wr),
	.wdata_in(fifo_ent),
	.rd_in(fifo_rd),
	.rdata_out(fifo_head),
	.count_out(fifo_cnt),
	.full_out(fifo_full),
	.empty_out(fifo_empty)
);

// choose what enters the byte store this cycle
always @* begin
	fifo_wr = 1'b0;
	fifo_ent = {EW{1'b0}};
	tail_d = 1'b0;
	tail_ent_d = tail_ent_q;
	has_f = ev_abort | (n_q != 3'h0);
	f_ent = mk_ent(1'b1, ~ev_abort, ~ev_abort & crc_bad, n_q - 3'h1, asm_q);
	if (tail_q) begin
		fifo_wr = 1'b1;
		fifo_ent = tail_ent_q;
	end else if (ev_first) begin
		fifo_wr = 1'b1;
		fifo_ent = mk_ent(1'b1, 1'b1, 1'b0, `FDH_NVB_RST, 8'h00);
	end else if (end_frame | ev_abort) begin
		if (pend_v_q & has_f) begin
			fifo_wr = 1'b1;
			fifo_ent = mk_ent(1'b0, flg_q, 1'b0, `FDH_NVB_RST, pend_q);
			tail_d = 1'b1;
			tail_ent_d = f_ent;
		end else if (pend_v_q) begin
			fifo_wr = 1'b1;
			fifo_ent = mk_ent(1'b1, ~ev_abort, ~ev_abort & crc_bad, `FDH_NVB_RST, pend_q);
		end else if (has_f) begin
			fifo_wr = 1'b1;
			fifo_ent = f_ent;
		end
	end else if (byte_done & pend_v_q) begin
		fifo_wr = 1'b1;
		fifo_ent = mk_ent(1'b0, flg_q, 1'b0, `FDH_NVB_RST, pend_q);
	end
end

// serial side: flag hunt, zero removal and byte assembly
always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		st_q <= ST_ONES;
		ones_q <= 3'h0;
		dly_q <= 7'h00;
		dcnt_q <= 3'h0;
		asm_q <= 8'h00;
		n_q <= 3'h0;
		pend_q <= 8'h00;
		pend_v_q <= 1'b0;
		tail_q <= 1'b0;
		tail_ent_q <= {EW{1'b0}};
		flg_q <= 1'b0;
	end else if (kill) begin
		st_q <= ST_ONES;
		ones_q <= 3'h0;
		dcnt_q <= 3'h0;
		n_q <= 3'h0;
		pend_v_q <= 1'b0;
		tail_q <= 1'b0;
		flg_q <= 1'b0;
	end else begin
		tail_q <= tail_d;
		tail_ent_q <= tail_ent_d;
		if (stb) begin
			if (rx_bit_in) begin
				ones_q <= (ones_q == `FDH_ONES_MAX) ? ones_q : ones_q + 3'h1;
			end else begin
				ones_q <= 3'h0;
			end
			if (is_flag) begin
				flg_q <= 1'b1;
				st_q <= ST_FLAGS;
				dcnt_q <= 3'h0;
				n_q <= 3'h0;
				pend_v_q <= 1'b0;
			end else if (is_abort) begin
				flg_q <= 1'b0;
				st_q <= ST_ONES;
				dcnt_q <= 3'h0;
				n_q <= 3'h0;
				pend_v_q <= 1'b0;
			end else if (push) begin
				dly_q <= {dly_q[5:0], rx_bit_in};
				if (dcnt_q != `FDH_DLY_FULL) begin
					dcnt_q <= dcnt_q + 3'h1;
				end
				if (exit_b) begin
					st_q <= ST_FRAME;
					asm_q <= asm_nx;
					n_q <= n_q + 3'h1;
					if (byte_done) begin
						pend_q <= asm_nx;
						pend_v_q <= 1'b1;
					end
				end
			end
		end
	end
end

// status, overrun and interrupt state
always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		ovr_q <= 1'b0;
		ovr_irq_q <= 1'b0;
		lat_q <= 1'b0;
		und_q <= 1'b0;
		stat_q <= `FDH_STAT_RST;
		irq_q <= 1'b0;
		eom_out_q <= 1'b0;
	end else begin
		if (ovr_set) begin
			ovr_q <= 1'b1;
		end else if (rd_stat) begin
			ovr_q <= 1'b0;
		end
		if (ovr_set) begin
			ovr_irq_q <= 1'b1;
		end else if (rd_stat | restart) begin
			ovr_irq_q <= 1'b0;
		end
		if (lat_set) begin
			lat_q <= 1'b1;
		end else if (lat_clr) begin
			lat_q <= 1'b0;
		end
		if (rd_data & fifo_empty) begin
			und_q <= 1'b1;
		end else if (rd_stat) begin
			und_q <= 1'b0;
		end
		if (kill) begin
			stat_q <= `FDH_STAT_RST;
		end else if (fifo_rd) begin
			stat_q <= fifo_head[EW-1:8];
		end
		irq_q <= (sel_q != 2'b00) & (lat_q | ovr_irq_q);
		eom_out_q <= eom_view;
	end
end

// AHB-Lite slave: every transfer gets one wait state
always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		ap_q <= 1'b0;
		ap_wr_q <= 1'b0;
		ap_hit_q <= 1'b0;
		ap_idx_q <= 8'h00;
		hready_q <= 1'b1;
		hresp_q <= 1'b0;
		hrdata_q <= 32'h00000000;
		en_q <= 1'b0;
		tr_q <= 1'b0;
		sel_q <= 2'b00;
	end else begin
		hresp_q <= 1'b0;
		if (hsel_in & htrans_in[1] & hready_in) begin
			ap_q <= 1'b1;
			ap_wr_q <= hwrite_in;
			ap_idx_q <= haddr_in[9:2];
			ap_hit_q <= (haddr_in[31:10] == 22'h000000) & (haddr_in[1:0] == 2'b00);
			hready_q <= 1'b0;
		end else if (ap_q) begin
			ap_q <= 1'b0;
			hready_q <= 1'b1;
		end
		if (wr_cfg) begin
			en_q <= hwdata_in[`FDH_CFG_EN];
		end
		tr_q <= wr_cfg & hwdata_in[`FDH_CFG_TR];
		if (wr_irq) begin
			sel_q <= hwdata_in[`FDH_IRQ_SEL_HI:`FDH_IRQ_SEL_LO];
		end
		if (ap_q & ~ap_wr_q) begin
			if (hit_cfg) begin
				hrdata_q <= {30'h0, tr_q, en_q};
			end else if (hit_irq) begin
				hrdata_q <= {29'h0, sel_q, int_bit};
			end else if (hit_stat) begin
				hrdata_q <= {24'h000000, stat_byte};
			end else if (hit_data) begin
				hrdata_q <= {24'h000000, fifo_empty ? 8'h00 : fifo_head[7:0]};
			end else begin
				hrdata_q <= 32'h00000000;
			end
		end
	end
end

assign hreadyout_out = hready_q;
assign hrdata_out = hrdata_q;
assign hresp_out = hresp_q;
assign rx_link_irq_out = irq_q;
assign rx_frame_end_out = eom_out_q;
endmodule

// File: test/fdh_rx_props.sv
// Purpose: port-level checks for the link frame receiver
// Assumes: one clock domain, reset asynchronous and active high
// Notes: helper logic follows bus writes to recover enable, select and terminate
`timescale 1ns/1ps
module fdh_rx_props (
	input wire clock_in,
	input wire rst_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	input wire hreadyout_out,
	input wire [31:0] hrdata_out,
	input wire hresp_out,
	input wire rx_link_irq_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	wire acc = hsel_in & htrans_in[1] & hready_in;
	wire fin = !hreadyout_out;
	reg wr_q, rd_q, en_q, term_q;
	reg [7:0] a_q;
	reg [1:0] sel_q;
	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			{wr_q, rd_q, en_q, term_q, a_q, sel_q} <= '0;
		end else begin
			term_q <= fin & wr_q & a_q == 8'hE0 & hwdata_in[1];
			if (fin & wr_q & a_q == 8'hE0) en_q <= hwdata_in[0];
			if (fin & wr_q & a_q == 8'hE4) sel_q <= hwdata_in[2:1];
			if (acc) begin
				wr_q <= hwrite_in;
				rd_q <= !hwrite_in;
				a_q <= haddr_in[7:0];
			end else if (fin) begin
				wr_q <= 1'h0;
				rd_q <= 1'h0;
			end
		end
	end
	chk_one_wait: assert property (acc |=> !hreadyout_out ##1 hreadyout_out)
		else $error("bus transfer did not take exactly one wait state");
	chk_resp_okay: assert property (!hresp_out)
		else $error("error response seen");
	chk_sel_off: assert property (sel_q == 2'h0 && $past(sel_q) == 2'h0 |-> !rx_link_irq_out)
		else $error("interrupt output high with select off");
	chk_dis_clear: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |-> !rx_link_irq_out)
		else $error("interrupt output high while disabled");
	chk_term_clear: assert property (term_q |-> ##3 !rx_link_irq_out)
		else $error("interrupt not cleared by terminate");
	chk_irq_cause: assert property ($rose(rx_link_irq_out) |-> en_q || $past(en_q))
		else $error("interrupt rose while disabled");
	chk_term_read: assert property (rd_q && fin && a_q == 8'hE0 |=> !hrdata_out[1])
		else $error("terminate bit read back as one");
	chk_irq_mirror: assert property (rd_q && fin && a_q == 8'hE4 && sel_q != 2'h0
		|=> hrdata_out[0] == $past(rx_link_irq_out))
		else $error("interrupt status bit differs from output");
	chk_unmapped: assert property (rd_q && fin && (a_q < 8'hE0 || a_q > 8'hEC)
		|=> hrdata_out == 32'h0)
		else $error("unmapped read returned nonzero");
	cover property ($rose(rx_link_irq_out));
	cover property (term_q);
	cover property (rd_q && fin && a_q == 8'hEC);
endmodule
bind fdh_link_frame_receiver fdh_rx_props fdh_rx_props_inst (.clock_in, .rst_in, .hsel_in,
	.haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hrdata_out,
	.hresp_out, .rx_link_irq_out);

// File: test/fdh_link_source.sv
// Purpose: framer-side model feeding link bits with one-cycle strobes
// Assumes: tasks are entered just after a rising clock edge
// Notes: the bit line is inverted between strobes, it carries nothing then
`timescale 1ns/1ps
module fdh_link_source (
	input wire clock_in,
	output logic bit_out,
	output logic stb_out
);
	int ones = 0;
	initial begin
		bit_out = 1'h0;
		stb_out = 1'h0;
	end
	task automatic emit(input logic v);
		bit_out <= v;
		stb_out <= 1'h1;
		@(posedge clock_in);
		bit_out <= ~v;
		stb_out <= 1'h0;
		repeat (4) @(posedge clock_in);
	endtask
	task automatic send(input logic [7:0] b, input logic stuff);
		for (int i = 0; i < 8; i++) begin
			emit(b[i]);
			ones = b[i] ? ones + 1 : 0;
			if (stuff && ones == 5) begin
				emit(1'h0);
				ones = 0;
			end
		end
	endtask
endmodule

// File: test/testbench.sv
// Purpose: self-checking bench for the link frame receiver
// Assumes: one wait state per bus transfer, link bits five clocks apart
// Notes: scenarios run in sequence and each leaves the receiver in a known state
`timescale 1ns/1ps
`include "fdh_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, (e), (g)); end end
module testbench;
	logic clock_in = 1'h0;
	logic rst_in = 1'h1;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] rd;
	wire hready, hresp, irq, feom, rbit, rstb;
	wire [31:0] hrdata;
	int n_fail = 0;
	int n_compared = 0;
	always #2.5 clock_in = ~clock_in;
	fdh_link_frame_receiver fdh_link_frame_receiver_inst (.clock_in(clock_in), .rst_in(rst_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
		.hrdata_out(hrdata), .hresp_out(hresp), .rx_bit_in(rbit), .rx_bit_stb_in(rstb),
		.rx_link_irq_out(irq), .rx_frame_end_out(feom));
	fdh_link_source fdh_link_source_inst (.clock_in(clock_in), .bit_out(rbit), .stb_out(rstb));
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wait_ready();
		int n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (hready !== 1'h1 && n < 20);
		if (hready !== 1'h1) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata[7:0];
	endtask
	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] m,
		input logic [7:0] e);
		bus(1'h0, idx, 8'h00);
		`CHK(nm, e, rd & m)
	endtask
	task automatic tx(input logic [7:0] b, input logic s);
		fdh_link_source_inst.send(b, s);
	endtask
	task automatic hunt();
		tx(8'hFF, 1'h0);
		tx(8'h7E, 1'h0);
	endtask
	task automatic drain();
		rd = 8'h00;
		for (int n = 0; n < 5 && rd[4] !== 1'h1; n++) begin
			bus(1'h0, `FDH_IDX_DATA, 8'h00);
			bus(1'h0, `FDH_IDX_STAT, 8'h00);
		end
	endtask
	function automatic logic [15:0] fcs(input logic [7:0] b);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'h8408 : 16'h0000);
		return ~c;
	endfunction
	task automatic t_reset();
		rchk("status", `FDH_IDX_STAT, 8'hFF, 8'h87);
		rchk("config", `FDH_IDX_CFG, 8'hFF, 8'h00);
		rchk("irq ctl", `FDH_IDX_IRQ, 8'hFF, 8'h00);
		rchk("unmapped", 8'h3C, 8'hFF, 8'h00);
	endtask
	task automatic t_select();
		for (int s = 0; s < 4; s++) begin
			bus(1'h0 + 1'h1, `FDH_IDX_CFG, 8'h00);
			bus(1'h1, `FDH_IDX_IRQ, 8'(s * 2));
			bus(1'h1, `FDH_IDX_CFG, 8'h01);
			hunt();
			`CHK("flag irq", s != 0, irq)
			rchk("irq ctl", `FDH_IDX_IRQ, 8'h01, 8'h01);
			rchk("dummy", `FDH_IDX_DATA, 8'hFF, 8'h00);
			rchk("dummy st", `FDH_IDX_STAT, 8'hF0, 8'hB0);
			`CHK("drained irq", 1'h0, irq)
			repeat (s + 1) tx(8'h11, 1'h1);
			`CHK("below fill", 1'h0, irq)
			tx(8'h11, 1'h1);
			`CHK("at fill", s != 0, irq)
		end
		bus(1'h1, `FDH_IDX_CFG, 8'h00);
		rchk("sel kept", `FDH_IDX_IRQ, 8'hFF, 8'h06);
		rchk("cleared", `FDH_IDX_STAT, 8'h80, 8'h80);
		`CHK("irq off", 1'h0, irq)
	endtask
	task automatic t_frame(input logic bad);
		logic [15:0] f;
		f = fcs(8'hA5) ^ {15'h0, bad};
		tx(8'hA5, 1'h1);
		tx(f[7:0], 1'h1);
		tx(f[15:8], 1'h1);
		tx(8'h7E, 1'h0);
		rchk("first byte", `FDH_IDX_DATA, 8'hFF, 8'hA5);
		drain();
		`CHK("frame end", {4'hB, bad, 3'h7}, rd)
		`CHK("end pin", 1'h1, feom)
		`CHK("frame irq", 1'h0, irq)
	endtask
	task automatic t_abort_term_ovr();
		tx(8'hA5, 1'h1);
		tx(8'hA5, 1'h1);
		tx(8'h7F, 1'h0);
		`CHK("abort irq", 1'h1, irq)
		drain();
		`CHK("abort st", 2'h1, rd[5:4])
		tx(8'h7E, 1'h0);
		tx(8'h5A, 1'h1);
		bus(1'h1, `FDH_IDX_CFG, 8'h03);
		rchk("term bit", `FDH_IDX_CFG, 8'hFF, 8'h01);
		rchk("term empty", `FDH_IDX_STAT, 8'h80, 8'h80);
		rchk("underrun", `FDH_IDX_DATA, 8'hFF, 8'h00);
		rchk("underrun st", `FDH_IDX_STAT, 8'hFF, 8'h00);
		hunt();
		`CHK("refl irq", 1'h1, irq)
		repeat (8) tx(8'h11, 1'h1);
		`CHK("ovr irq", 1'h1, irq)
		`CHK("ovr pin", 1'h1, feom)
		rchk("ovr st", `FDH_IDX_STAT, 8'hF0, 8'hD0);
		rchk("ovr gone", `FDH_IDX_STAT, 8'h40, 8'h00);
	endtask
	initial begin
		repeat (16) @(posedge clock_in);
		rst_in <= 1'h0;
		@(posedge clock_in);
		t_reset();
		t_select();
		bus(1'h1, `FDH_IDX_IRQ, 8'h02);
		bus(1'h1, `FDH_IDX_CFG, 8'h01);
		hunt();
		drain();
		t_frame(1'h0);
		t_frame(1'h1);
		t_abort_term_ovr();
		conclude();
	end
	initial begin
		#400000;
		n_fail++;
		conclude();
	end
endmodule
